// ==== common/tmpm_pkg.sv ====
// ==========================================================
// Shared constants of the pointer-addressed register bank
package tmpm_pkg;

  // ==========================================================
  // Serial engine states
  typedef enum logic [2:0] {
    TMPM_IDLE     = 3'b000,
    TMPM_ADDR     = 3'b001,
    TMPM_ADDR_ACK = 3'b010,
    TMPM_WR_BYTE  = 3'b011,
    TMPM_WR_ACK   = 3'b100,
    TMPM_RD_BYTE  = 3'b101,
    TMPM_RD_ACK   = 3'b110
  } tmpm_state_t;

  // ==========================================================
  // Bus framing constants
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // ==========================================================
  // Fixed index values, result reset and empty read value
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] IDX_NEAR_HI = 8'h00;
  localparam logic [7:0] IDX_FAR_HI = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_ONE_SHOT = 8'h0f;
  localparam logic [7:0] IDX_FAR_LO = 8'h10;
  localparam logic [7:0] IDX_NEAR_LO = 8'h15;
  localparam logic [7:0] IDX_MAKER = 8'hfe;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // ==========================================================
  // Settings slots, slot 0 is the rightmost table entry
  localparam int NSLOT = 17;
  localparam int SLOT_SETUP = 0;
  localparam int SLOT_INTERVAL = 1;
  localparam int SLOT_NEAR_UP = 2;
  localparam int SLOT_NEAR_LOW = 3;
  localparam int SLOT_FAR_UP_HI = 4;
  localparam int SLOT_FAR_LOW_HI = 5;
  localparam int SLOT_SHIFT_HI = 6;
  localparam int SLOT_SHIFT_LO = 7;
  localparam int SLOT_FAR_UP_LO = 8;
  localparam int SLOT_FAR_LOW_LO = 9;
  localparam int SLOT_CHANNELS = 10;
  localparam int SLOT_FAR_SHUT = 11;
  localparam int SLOT_NEAR_SHUT = 12;
  localparam int SLOT_BACKOFF = 13;
  localparam int SLOT_FAULT_CNT = 14;
  localparam int SLOT_IDEALITY = 15;
  localparam int SLOT_FILTER = 16;

  // Read index per slot
  localparam logic [16:0][7:0] RD_IDX = {
    8'h24, 8'h23, 8'h22, 8'h21, 8'h20, 8'h19, 8'h16, 8'h14, 8'h13,
    8'h12, 8'h11, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03};
  // Write index per slot
  localparam logic [16:0][7:0] WR_IDX = {
    8'h24, 8'h23, 8'h22, 8'h21, 8'h20, 8'h19, 8'h16, 8'h14, 8'h13,
    8'h12, 8'h11, 8'h0e, 8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'h09};
  // Power-on value per slot
  localparam logic [16:0][7:0] RST_VAL = {
    8'h00, 8'h00, 8'h01, 8'h0a, 8'h7f, 8'h7f, 8'h03, 8'h00, 8'hf0,
    8'h00, 8'h00, 8'h80, 8'h7f, 8'h80, 8'h7f, 8'h08, 8'h00};
  // Writable bits per slot
  localparam logic [16:0][7:0] WR_MASK = {
    8'h03, 8'hff, 8'h0e, 8'hff, 8'hff, 8'hff, 8'h03, 8'hf0, 8'hf0,
    8'hf0, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'he4};
  // Bits fixed at one per slot
  localparam logic [16:0][7:0] FIX_ONE = {
    8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ==========================================================
  // Field positions
  localparam int BIT_ALARM_SUPPRESS = 7;
  localparam int BIT_SHUTDOWN = 6;
  localparam int BIT_PIN_FUNC = 5;
  localparam int BIT_RANGE = 2;
  localparam int BIT_NEAR_ON = 0;
  localparam int BIT_FAR_ON = 1;

endpackage : tmpm_pkg

// ==== src/tmpm_register_map.sv ====
`timescale 1ns/1ps

// Contract
// - An 8-bit index register selects the register reached by bus accesses.
// - The first byte after the address of every write loads the index, except in a general call.
// - Power-up and general-call reset clear the index to zero.
// - Any write to index 0F starts one conversion; nothing readable there.
// - Index 01 reads upper eight bits of remote result, reset 00.
// - Index 15 reads local fraction in bits 7..4, low nibble zero.
// - Local upper bound reads at 05, writes at 0B, resets 7F.
// - Local lower bound reads at 06, writes at 0C, resets 80.
// - Remote upper bound low byte at 13, fraction in 7..4, reset F0.
// - Remote offset high byte read and written at 11, reset 00.
// - Local shutdown threshold read and written at 20, reset 7F.
// - Remote shutdown threshold read and written at 19, reset 7F.
// - Filter register at 24 holds two bits, upper bits zero, reset 00.
// - Setup writes at 09, reads at 03; paired registers use split indices.
// - Reading one result byte freezes the other until a read at any other index.
module tmpm_register_map #(
  parameter logic [6:0] DEVICE_ADDR = 7'h4c,
  parameter logic [7:0] MAKER_ID = 8'ha5 // Arbitrary identity value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Two-wire pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  // Converter results and status
  input wire logic near_update,
  input wire logic [11:0] near_result,
  input wire logic far_update,
  input wire logic [11:0] far_result,
  input wire logic [7:0] event_flags,
  // Strobes to the core
  output logic one_shot_start,
  output logic status_read,
  output logic soft_reset,
  // Settings to the core
  output logic alarm_suppress,
  output logic shutdown_request,
  output logic pin_function_select,
  output logic wide_range,
  output logic [3:0] sample_interval_code,
  output logic [7:0] near_upper_bound,
  output logic [7:0] near_lower_bound,
  output logic [11:0] far_upper_bound,
  output logic [11:0] far_lower_bound,
  output logic [11:0] far_reading_shift,
  output logic near_channel_on,
  output logic far_channel_on,
  output logic [7:0] far_shutdown_threshold,
  output logic [7:0] near_shutdown_threshold,
  output logic [7:0] threshold_backoff,
  output logic [2:0] fault_count_setting,
  output logic [7:0] ideality_factor_trim,
  output logic [1:0] filter_depth
);

  // ==========================================================
  // Declarations
  tmpm_pkg::tmpm_state_t state;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [3:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic drive;
  logic first_byte;
  logic gc_mode;
  logic is_read;
  logic [7:0] index;
  logic [7:0] cfg [tmpm_pkg::NSLOT];
  logic [7:0] near_hi, near_lo, far_hi, far_lo;
  logic lock_nh, lock_nl, lock_fh, lock_fl;

  // Slot lookup: returns {hit, slot}
  function automatic logic [5:0] find_slot(input logic [7:0] idx,
                                           input logic [16:0][7:0] tbl);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < tmpm_pkg::NSLOT; i++) begin
      if (tbl[i] == idx) begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction : find_slot

  // ==========================================================
  // Pin synchronisers and bus conditions
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {scl_s1, scl_s2, scl_s3} <= 3'b111;
      {sda_s1, sda_s2, sda_s3} <= 3'b111;
    end else begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, scl_in};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, sda_in};
    end
  end

  // Edge and condition decode
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire gc_hit = (rx_sh == tmpm_pkg::GC_ADDR_BYTE);
  wire addr_hit = (rx_sh[7:1] == DEVICE_ADDR) | gc_hit;
  wire byte_done = (state == tmpm_pkg::TMPM_WR_BYTE) & scl_fall &
                   (bit_cnt == tmpm_pkg::BITS_PER_BYTE);
  wire idx_load = byte_done & first_byte & ~gc_mode;
  wire wr_stb = byte_done & ~first_byte & ~gc_mode;
  wire gc_cmd = byte_done & first_byte & gc_mode & (rx_sh == tmpm_pkg::GC_RESET_CMD);
  wire tx_load = scl_fall & (((state == tmpm_pkg::TMPM_ADDR_ACK) & is_read) |
                             (state == tmpm_pkg::TMPM_RD_ACK));

  // Register lookup for read and write
  wire [5:0] rd_find = find_slot(index, tmpm_pkg::RD_IDX);
  wire [5:0] wr_find = find_slot(index, tmpm_pkg::WR_IDX);
  wire rd_hit = rd_find[5];
  wire [4:0] rd_slot = rd_find[4:0];
  wire wr_hit = wr_find[5];
  wire [4:0] wr_slot = wr_find[4:0];

  // Read data selection; write-only and unmapped indices read zero
  wire [7:0] rd_mux =
    rd_hit ? cfg[rd_slot] :
    (index == tmpm_pkg::IDX_NEAR_HI) ? near_hi :
    (index == tmpm_pkg::IDX_FAR_HI) ? far_hi :
    (index == tmpm_pkg::IDX_STATUS) ? event_flags :
    (index == tmpm_pkg::IDX_FAR_LO) ? far_lo :
    (index == tmpm_pkg::IDX_NEAR_LO) ? near_lo :
    (index == tmpm_pkg::IDX_MAKER) ? MAKER_ID :
    tmpm_pkg::READ_NONE;

  // Open-drain data pin, enable low while pulling low
  assign sda_out = 1'b0;
  assign sda_drive_n = ~drive;

  // ==========================================================
  // Serial engine
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= tmpm_pkg::TMPM_IDLE;
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      drive <= 1'b0;
      first_byte <= 1'b0;
      gc_mode <= 1'b0;
      is_read <= 1'b0;
    end else if (start_det) begin
      state <= tmpm_pkg::TMPM_ADDR;
      bit_cnt <= 4'h0;
      drive <= 1'b0;
    end else if (stop_det) begin
      state <= tmpm_pkg::TMPM_IDLE;
      drive <= 1'b0;
    end else begin
      unique case (state)
        tmpm_pkg::TMPM_IDLE: begin
          drive <= 1'b0;
        end
        tmpm_pkg::TMPM_ADDR, tmpm_pkg::TMPM_WR_BYTE: begin
          if (scl_rise && bit_cnt != tmpm_pkg::BITS_PER_BYTE) begin
            rx_sh <= {rx_sh[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == tmpm_pkg::BITS_PER_BYTE) begin
            if (state == tmpm_pkg::TMPM_WR_BYTE) begin
              drive <= 1'b1;
              first_byte <= 1'b0;
              state <= tmpm_pkg::TMPM_WR_ACK;
            end else if (addr_hit) begin
              drive <= 1'b1;
              is_read <= rx_sh[0];
              gc_mode <= gc_hit;
              first_byte <= 1'b1;
              state <= tmpm_pkg::TMPM_ADDR_ACK;
            end else begin
              state <= tmpm_pkg::TMPM_IDLE;
            end
          end
        end
        tmpm_pkg::TMPM_WR_ACK: begin
          if (scl_fall) begin
            drive <= 1'b0;
            bit_cnt <= 4'h0;
            state <= tmpm_pkg::TMPM_WR_BYTE;
          end
        end
        tmpm_pkg::TMPM_ADDR_ACK, tmpm_pkg::TMPM_RD_ACK: begin
          if (state == tmpm_pkg::TMPM_RD_ACK && scl_rise && sda_s2) begin
            state <= tmpm_pkg::TMPM_IDLE; // Master refused more data
          end else if (tx_load) begin
            tx_sh <= rd_mux;
            drive <= ~rd_mux[7];
            bit_cnt <= 4'h0;
            state <= tmpm_pkg::TMPM_RD_BYTE;
          end else if (scl_fall) begin
            drive <= 1'b0;
            bit_cnt <= 4'h0;
            state <= tmpm_pkg::TMPM_WR_BYTE;
          end
        end
        tmpm_pkg::TMPM_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt == tmpm_pkg::LAST_TX_BIT) begin
              drive <= 1'b0;
              state <= tmpm_pkg::TMPM_RD_ACK;
            end else begin
              tx_sh <= {tx_sh[6:0], 1'b0};
              drive <= ~tx_sh[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= tmpm_pkg::TMPM_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Index register and strobes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      index <= tmpm_pkg::INDEX_RESET;
    end else if (soft_reset) begin
      index <= tmpm_pkg::INDEX_RESET;
    end else if (idx_load) begin
      index <= rx_sh;
    end
  end

  // One-cycle strobes to the core
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      one_shot_start <= 1'b0;
      status_read <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      one_shot_start <= wr_stb & (index == tmpm_pkg::IDX_ONE_SHOT);
      status_read <= tx_load & (index == tmpm_pkg::IDX_STATUS);
      soft_reset <= gc_cmd;
    end
  end

  // ==========================================================
  // Settings storage, masked on write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < tmpm_pkg::NSLOT; i++) begin
        cfg[i] <= tmpm_pkg::RST_VAL[i];
      end
    end else if (soft_reset) begin
      for (int i = 0; i < tmpm_pkg::NSLOT; i++) begin
        cfg[i] <= tmpm_pkg::RST_VAL[i];
      end
    end else if (wr_stb && wr_hit) begin
      cfg[wr_slot] <= (rx_sh & tmpm_pkg::WR_MASK[wr_slot]) |
                      tmpm_pkg::FIX_ONE[wr_slot];
    end
  end

  // ==========================================================
  // Result bytes with read-pair locks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {near_hi, near_lo} <= {tmpm_pkg::RESULT_RESET, tmpm_pkg::RESULT_RESET};
      {far_hi, far_lo} <= {tmpm_pkg::RESULT_RESET, tmpm_pkg::RESULT_RESET};
    end else if (soft_reset) begin
      {near_hi, near_lo} <= {tmpm_pkg::RESULT_RESET, tmpm_pkg::RESULT_RESET};
      {far_hi, far_lo} <= {tmpm_pkg::RESULT_RESET, tmpm_pkg::RESULT_RESET};
    end else begin
      if (near_update && !lock_nh) near_hi <= near_result[11:4];
      if (near_update && !lock_nl) near_lo <= {near_result[3:0], 4'h0};
      if (far_update && !lock_fh) far_hi <= far_result[11:4];
      if (far_update && !lock_fl) far_lo <= {far_result[3:0], 4'h0};
    end
  end

  // Locks set by a read of one byte, cleared by a read at any other index
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {lock_nh, lock_nl, lock_fh, lock_fl} <= 4'h0;
    end else if (soft_reset) begin
      {lock_nh, lock_nl, lock_fh, lock_fl} <= 4'h0;
    end else if (tx_load) begin
      lock_nl <= (index == tmpm_pkg::IDX_NEAR_HI) & ~lock_nh;
      lock_nh <= (index == tmpm_pkg::IDX_NEAR_LO) & ~lock_nl;
      lock_fl <= (index == tmpm_pkg::IDX_FAR_HI) & ~lock_fh;
      lock_fh <= (index == tmpm_pkg::IDX_FAR_LO) & ~lock_fl;
    end
  end

  // ==========================================================
  // Settings fields to the core
  assign alarm_suppress = cfg[tmpm_pkg::SLOT_SETUP][tmpm_pkg::BIT_ALARM_SUPPRESS];
  assign shutdown_request = cfg[tmpm_pkg::SLOT_SETUP][tmpm_pkg::BIT_SHUTDOWN];
  assign pin_function_select = cfg[tmpm_pkg::SLOT_SETUP][tmpm_pkg::BIT_PIN_FUNC];
  assign wide_range = cfg[tmpm_pkg::SLOT_SETUP][tmpm_pkg::BIT_RANGE];
  assign sample_interval_code = cfg[tmpm_pkg::SLOT_INTERVAL][3:0];
  assign near_upper_bound = cfg[tmpm_pkg::SLOT_NEAR_UP];
  assign near_lower_bound = cfg[tmpm_pkg::SLOT_NEAR_LOW];
  assign far_upper_bound = {cfg[tmpm_pkg::SLOT_FAR_UP_HI], cfg[tmpm_pkg::SLOT_FAR_UP_LO][7:4]};
  assign far_lower_bound = {cfg[tmpm_pkg::SLOT_FAR_LOW_HI], cfg[tmpm_pkg::SLOT_FAR_LOW_LO][7:4]};
  assign far_reading_shift = {cfg[tmpm_pkg::SLOT_SHIFT_HI], cfg[tmpm_pkg::SLOT_SHIFT_LO][7:4]};
  assign near_channel_on = cfg[tmpm_pkg::SLOT_CHANNELS][tmpm_pkg::BIT_NEAR_ON];
  assign far_channel_on = cfg[tmpm_pkg::SLOT_CHANNELS][tmpm_pkg::BIT_FAR_ON];
  assign far_shutdown_threshold = cfg[tmpm_pkg::SLOT_FAR_SHUT];
  assign near_shutdown_threshold = cfg[tmpm_pkg::SLOT_NEAR_SHUT];
  assign threshold_backoff = cfg[tmpm_pkg::SLOT_BACKOFF];
  assign fault_count_setting = cfg[tmpm_pkg::SLOT_FAULT_CNT][3:1];
  assign ideality_factor_trim = cfg[tmpm_pkg::SLOT_IDEALITY];
  assign filter_depth = cfg[tmpm_pkg::SLOT_FILTER][1:0];

  // ==========================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_index_load: assert property (idx_load |=> index == $past(rx_sh))
    else $error("index not loaded from first byte");
  a_index_clear: assert property (soft_reset |=> index == 8'h00)
    else $error("index not cleared by reset");
  a_one_shot: assert property (wr_stb && index == 8'h0f |=> one_shot_start ##1 !one_shot_start)
    else $error("one-shot strobe wrong");
  a_far_high: assert property (far_update && !lock_fh |=> far_hi == $past(far_result[11:4]))
    else $error("remote high byte not updated");
  a_near_low: assert property (index == 8'h15 |-> rd_mux[3:0] == 4'h0)
    else $error("local low nibble not zero");
  a_near_upper: assert property (wr_stb && index == 8'h0b |=> near_upper_bound == $past(rx_sh))
    else $error("local upper bound not written");
  a_near_lower: assert property (wr_stb && index == 8'h0c |=> near_lower_bound == $past(rx_sh))
    else $error("local lower bound not written");
  a_far_up_low: assert property (index == 8'h13 |-> rd_mux[3:0] == 4'h0)
    else $error("remote bound fraction low nibble set");
  a_pair_lock: assert property (lock_nl && near_update && !tx_load && !soft_reset |=> $stable(near_lo))
    else $error("locked low byte changed");
  a_dead_write: assert property (wr_stb && !wr_hit |=> $stable(index) && cfg[0] == $past(cfg[0]))
    else $error("unwritable index changed state");
  a_fixed_one: assert property (index == 8'h22 |-> rd_mux[0] && rd_mux[7:4] == 4'h0)
    else $error("fixed bits read wrong");

endmodule : tmpm_register_map

// ==== tb/tmpm_host.sv ====
`timescale 1ns/1ps
// ==========================================================
// Two-wire bus master, 80 ns bus clock, still between frames
module tmpm_host (
  // Clock
  input wire logic ref_clk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_h
);
  // Idle bus, both lines released high
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end

  // Quarter of a bus clock period
  task automatic q();
    repeat (4) @(posedge ref_clk);
  endtask : q

  // One bus clock pulse, data set while low, sampled mid-high
  task automatic xbit(input logic b, output logic r);
    sda_h <= b;
    q();
    scl <= 1'b1;
    q();
    r = sda_line;
    q();
    scl <= 1'b0;
    q();
  endtask : xbit

  // Start or repeated start
  task automatic start();
    sda_h <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_h <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask : start

  // Stop, bus left idle
  task automatic stop();
    sda_h <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_h <= 1'b1;
    q();
  endtask : stop

  // Byte out MSB first, then the ninth pulse for the acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask : send_byte

  // Byte in MSB first, line released; nack high ends the read
  task automatic recv_byte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(nack, r);
  endtask : recv_byte
endmodule : tmpm_host

// ==== tb/tmpm_register_map_tb.sv ====
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the register bank
module tmpm_register_map_tb;
  localparam logic [6:0] ADDR = 7'h4c;
  localparam logic [7:0] ID_VAL = 8'h3b; // Arbitrary identity value
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_h, sda_out, sda_drive_n;
  wire logic sda_line = sda_h & (sda_drive_n | sda_out); // Open drain, pull-up
  logic near_update = 1'b0;
  logic far_update = 1'b0;
  logic [11:0] near_result = 12'h000;
  logic [11:0] far_result = 12'h000;
  logic [7:0] event_flags = 8'h3c;
  logic one_shot_start, status_read, soft_reset, alarm_suppress, shutdown_request;
  logic pin_function_select, wide_range, near_channel_on, far_channel_on;
  logic [3:0] sample_interval_code;
  logic [7:0] near_upper_bound, near_lower_bound, far_shutdown_threshold;
  logic [7:0] near_shutdown_threshold, threshold_backoff, ideality_factor_trim;
  logic [11:0] far_upper_bound, far_lower_bound, far_reading_shift;
  logic [2:0] fault_count_setting;
  logic [1:0] filter_depth;
  int fail_count = 0;
  int checked = 0;
  int n_shot = 0;
  int n_stat = 0;
  int n_soft = 0;

  // Clock
  always #2.5 ref_clk = ~ref_clk;

  // Device and host
  tmpm_register_map #(.DEVICE_ADDR(ADDR), .MAKER_ID(ID_VAL)) u_dut (
    .ref_clk, .rst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_drive_n,
    .near_update, .near_result, .far_update, .far_result, .event_flags,
    .one_shot_start, .status_read, .soft_reset, .alarm_suppress, .shutdown_request,
    .pin_function_select, .wide_range, .sample_interval_code, .near_upper_bound,
    .near_lower_bound, .far_upper_bound, .far_lower_bound, .far_reading_shift,
    .near_channel_on, .far_channel_on, .far_shutdown_threshold,
    .near_shutdown_threshold, .threshold_backoff, .fault_count_setting,
    .ideality_factor_trim, .filter_depth);
  tmpm_host u_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_h(sda_h));

  // Strobe pulse counters
  always @(posedge ref_clk) begin
    if (one_shot_start === 1'b1) n_shot++;
    if (status_read === 1'b1) n_stat++;
    if (soft_reset === 1'b1) n_soft++;
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic tend(input string name);
    $display("test %s done", name);
  endtask : tend

  // Write transaction: index byte then one data byte
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic a0, a1, a2;
    u_host.start();
    u_host.send_byte({ADDR, 1'b0}, a0);
    u_host.send_byte(idx, a1);
    u_host.send_byte(d, a2);
    u_host.stop();
    chk("write acks", 12'h007, {9'h000, a0, a1, a2});
  endtask : wr_reg

  // Read transaction at the current index, single byte
  task automatic rd_now(output logic [7:0] d);
    logic a;
    u_host.start();
    u_host.send_byte({ADDR, 1'b1}, a);
    u_host.recv_byte(d, 1'b1);
    u_host.stop();
    chk("read ack", 12'h001, {11'h000, a});
  endtask : rd_now

  // Index write, repeated start, read, compare
  task automatic chkreg(input logic [7:0] idx, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    u_host.start();
    u_host.send_byte({ADDR, 1'b0}, a);
    u_host.send_byte(idx, a);
    rd_now(d);
    chk($sformatf("register %h", idx), {4'h0, exp}, {4'h0, d});
  endtask : chkreg

  // Converter result pulse
  task automatic pulse(input logic far, input logic [11:0] v);
    @(posedge ref_clk);
    if (far) begin
      far_result <= v;
      far_update <= 1'b1;
    end else begin
      near_result <= v;
      near_update <= 1'b1;
    end
    @(posedge ref_clk);
    far_update <= 1'b0;
    near_update <= 1'b0;
  endtask : pulse

  // Main sequence
  initial begin
    logic [7:0] d;
    logic a0, a1;
    logic [7:0] ro [4] = '{8'h00, 8'h02, 8'h15, 8'hfe};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pulse(1'b0, 12'h5a3);
    rd_now(d);
    chk("index after reset", 12'h05a, {4'h0, d});
    tend("reset_index");
    chkreg(8'h01, 8'h00);
    for (int i = 0; i < tmpm_pkg::NSLOT; i++) begin
      chkreg(tmpm_pkg::RD_IDX[i], tmpm_pkg::RST_VAL[i]);
    end
    chk("near_lower_bound", 12'h080, {4'h0, near_lower_bound});
    tend("power_on");
    for (int i = 0; i < tmpm_pkg::NSLOT; i++) begin
      wr_reg(tmpm_pkg::WR_IDX[i], 8'hff);
      chkreg(tmpm_pkg::RD_IDX[i], tmpm_pkg::WR_MASK[i] | tmpm_pkg::FIX_ONE[i]);
    end
    chk("near_upper_bound", 12'h0ff, {4'h0, near_upper_bound});
    chk("far_upper_bound", 12'hfff, far_upper_bound);
    chk("filter_depth", 12'h003, {10'h000, filter_depth});
    chk("setup bits", 12'h0ff, {4'h0, alarm_suppress, shutdown_request, pin_function_select,
                                wide_range, sample_interval_code});
    chk("far_lower_bound", 12'hfff, far_lower_bound);
    chk("far_reading_shift", 12'hfff, far_reading_shift);
    chk("channels and count", 12'h01f, {7'h00, near_channel_on, far_channel_on,
                                        fault_count_setting});
    chk("far_shutdown_threshold", 12'h0ff, {4'h0, far_shutdown_threshold});
    chk("near_shutdown_threshold", 12'h0ff, {4'h0, near_shutdown_threshold});
    chk("threshold_backoff", 12'h0ff, {4'h0, threshold_backoff});
    chk("ideality_factor_trim", 12'h0ff, {4'h0, ideality_factor_trim});
    chk("sda_out", 12'h000, {11'h000, sda_out});
    wr_reg(8'h05, 8'h12);
    chkreg(8'h05, 8'hff);
    wr_reg(8'h22, 8'h00);
    chkreg(8'h22, 8'h01);
    wr_reg(8'h20, 8'h44);
    rd_now(d);
    chk("index from write", 12'h044, {4'h0, d});
    tend("split_index");
    for (int i = 0; i < 4; i++) wr_reg(ro[i], 8'hff);
    chkreg(8'h00, 8'h5a);
    chkreg(8'h15, 8'h30);
    chkreg(8'hfe, ID_VAL);
    tend("read_only");
    wr_reg(8'h0f, 8'ha5);
    wr_reg(8'h0f, 8'h00);
    chk("one shot pulses", 12'h002, n_shot[11:0]);
    chkreg(8'h0f, 8'h00);
    tend("one_shot");
    chkreg(8'h00, 8'h5a);
    pulse(1'b0, 12'h7c1);
    chkreg(8'h15, 8'h30);
    chkreg(8'h02, 8'h3c);
    pulse(1'b0, 12'h7c1);
    chkreg(8'h00, 8'h7c);
    chkreg(8'h15, 8'h10);
    pulse(1'b1, 12'h9e5);
    chkreg(8'h10, 8'h50);
    pulse(1'b1, 12'h123);
    chkreg(8'h01, 8'h9e);
    tend("result_lock");
    chkreg(8'h02, 8'h3c);
    chk("status strobes", 12'h002, n_stat[11:0]);
    u_host.start();
    u_host.send_byte(8'h00, a0);
    u_host.send_byte(8'h06, a1);
    u_host.stop();
    chk("general call acks", 12'h003, {10'h000, a0, a1});
    chk("soft reset pulses", 12'h001, n_soft[11:0]);
    rd_now(d);
    chk("index after soft reset", 12'h000, {4'h0, d});
    chk("near_upper_bound", 12'h07f, {4'h0, near_upper_bound});
    u_host.start();
    u_host.send_byte({7'h4d, 1'b0}, a0);
    u_host.stop();
    chk("foreign address ack", 12'h000, {11'h000, a0});
    tend("general_call");
    test_done();
  end

  // Watchdog
  initial begin
    repeat (90000) @(posedge ref_clk);
    fail_count++;
    $display("mismatch watchdog expected finish seen timeout");
    test_done();
  end
endmodule : tmpm_register_map_tb
